/* src/brg_rate_generator.sv */
// baud rate generator with register port and majority-vote receive sampling
//
// What this block does
// - one 8-bit timer serves asynchronous and synchronous master modes, is held at zero as synchronous slave, and its period is set by the divisor register.
// - asynchronous low speed gives one tick per 64 times (divisor plus one) clocks.
// - asynchronous high speed gives one tick per 16 times (divisor plus one) clocks.
// - synchronous mode gives one tick per 4 times (divisor plus one) clocks, with no high-speed form.
// - the high-speed bit is ignored in synchronous mode.
// - ticks come from the generator in asynchronous mode and as synchronous clock master; a synchronous slave gets no generator ticks.
// - any divisor write clears the timer and prescaler so the new rate starts at once.
// - the receive pin is sampled three times and a majority vote decides its level.
// - every divisor value 0 to 255 is valid and counted unsigned.
// - the divisor clears to zero at every reset.
// - in synchronous mode the clock source bit set makes the block master, cleared makes it slave.
module brg_rate_generator
  import brg_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire brg_pkg::brg_bus_req_t busReq,
  output logic [7:0]              rdData,
  input  wire logic               rxPin,
  output logic                    rateTick,
  output logic                    rxLevel,
  output logic                    syncMaster
);
  import brg_pkg::*;

  // register map, two address bits:
  //   0 transmit_control_status: bit7 clock source, bit4 sync mode, bit2 high speed,
  //     bit1 shift-empty (read-only, reset high), bit3 unimplemented and read as zero
  //   1 receive_control_status: bits 7..3 writable, bits 2..0 read-only and zero here
  //   2 baud_divisor: all eight bits, any value is a valid unsigned count
  //   3 status, read-only: bit2 voted receive level, bit1 sync master, bit0 timer at zero
  // writes to address 3 are dropped; read data stand only in the cycle after the strobe
  // and read as zero otherwise, so several slaves can be or-ed onto one return bus
  //
  // tick timing: a divisor write clears prescaler and timer on the next edge; the
  // first tick then shows (divisor+1)*divide cycles later and repeats at that spacing.
  // a mode change other than into or out of sync slave does not restart the count, so the first period after it may
  // be short or long; software that cares writes the divisor afterwards.
  // limitation: the shift logic lives elsewhere, this block only hands out the tick
  // and the voted receive level; it keeps no frame state of its own.
  // trade-off: the status word exposes timer-at-zero so software can line up a
  // divisor write with a period boundary without an interrupt.

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] txCtrl_reg, txCtrl_next;
  logic [7:0] rxCtrl_reg, rxCtrl_next;
  logic [7:0] divisor_reg, divisor_next;
  logic [5:0] prescale_reg, prescale_next;
  logic [7:0] timer_reg, timer_next;
  logic       tick_reg, tick_next;
  logic [7:0] rdData_reg, rdData_next;
  logic       rxSync1_reg, rxSync2_reg;
  logic [2:0] rxSamples_reg, rxSamples_next;
  logic       rxLevel_reg, rxLevel_next;
  logic       master_reg, master_next;
  logic [5:0] prescaleTop;
  logic       syncMode;
  logic       genEnable;
  logic       divWrite;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  // the prescaler top picks the divide: 4, 16 or 64 clocks per timer count.
  // a sync slave takes its bit clock from the far end, so the generator is held
  // at zero there instead of running unused and wasting toggles
  always_comb
  begin
    syncMode = txCtrl_reg[TX_SYNC_MODE_BIT];
    // high-speed bit only consulted in async mode
    if (syncMode)
      prescaleTop = PRESCALE_SYNC;
    else if (txCtrl_reg[TX_HIGH_SPEED_BIT])
      prescaleTop = PRESCALE_ASYNC_HIGH;
    else
      prescaleTop = PRESCALE_ASYNC_LOW;
    // a sync slave is clocked from outside, so the generator stays quiet
    genEnable = !syncMode || txCtrl_reg[TX_CLOCK_SOURCE_BIT];
    divWrite  = busReq.wr && (busReq.addr == ADDR_DIVISOR);
  end

  ////////////////////////////////////////////////////////////////////////
  // register file next values
  // read-only bits are merged back from the current value through the write mask,
  // so a software read-modify-write can never disturb them.
  // read data default to zero to keep the return bus quiet between reads
  always_comb
  begin
    txCtrl_next  = txCtrl_reg;
    rxCtrl_next  = rxCtrl_reg;
    divisor_next = divisor_reg;
    rdData_next  = 8'h00;
    if (busReq.wr)
    begin
      if (busReq.addr == ADDR_TX_CTRL)
        txCtrl_next = (busReq.wdata & TX_CTRL_WMASK) | (txCtrl_reg & ~TX_CTRL_WMASK);
      else if (busReq.addr == ADDR_RX_CTRL)
        rxCtrl_next = (busReq.wdata & RX_CTRL_WMASK) | (rxCtrl_reg & ~RX_CTRL_WMASK);
      else if (busReq.addr == ADDR_DIVISOR)
        divisor_next = busReq.wdata;
    end
    if (busReq.rd)
    begin
      if (busReq.addr == ADDR_TX_CTRL)
        rdData_next = txCtrl_reg;
      else if (busReq.addr == ADDR_RX_CTRL)
        rdData_next = rxCtrl_reg;
      else if (busReq.addr == ADDR_DIVISOR)
        rdData_next = divisor_reg;
      else
        rdData_next = {5'h00, rxLevel_reg, master_reg, timer_reg == 8'h00};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txCtrl_reg  <= TX_CTRL_RESET;
      rxCtrl_reg  <= RX_CTRL_RESET;
      divisor_reg <= DIVISOR_RESET;
      rdData_reg  <= 8'h00;
    end
    else
    begin
      txCtrl_reg  <= txCtrl_next;
      rxCtrl_reg  <= rxCtrl_next;
      divisor_reg <= divisor_next;
      rdData_reg  <= rdData_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler and 8-bit timer
  // the prescaler wraps with >= rather than == so that a switch to a smaller
  // divide while it sits above the new top cannot run it round all 64 states.
  // the timer counts up to the divisor and compares, so a divisor of zero gives
  // one tick per prescaler wrap and 255 gives the slowest rate
  always_comb
  begin
    prescale_next = prescale_reg;
    timer_next    = timer_reg;
    tick_next     = 1'b0;
    master_next   = syncMode && txCtrl_reg[TX_CLOCK_SOURCE_BIT];
    if (divWrite || !genEnable)
    begin
      // restart from zero so the new rate needs no wait for overflow
      prescale_next = 6'h00;
      timer_next    = 8'h00;
    end
    else if (prescale_reg >= prescaleTop)
    begin
      prescale_next = 6'h00;
      if (timer_reg == divisor_reg)
      begin
        timer_next = 8'h00;
        tick_next  = 1'b1;
      end
      else
        timer_next = timer_reg + 8'h01;
    end
    else
      prescale_next = prescale_reg + 6'h01;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prescale_reg <= 6'h00;
      timer_reg    <= 8'h00;
      tick_reg     <= 1'b0;
      master_reg   <= 1'b0;
    end
    else
    begin
      prescale_reg <= prescale_next;
      timer_reg    <= timer_next;
      tick_reg     <= tick_next;
      master_reg   <= master_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive pin: two-flop sync, then three-sample majority
  // the vote rejects a one-cycle glitch at the cost of about five cycles of delay;
  // reset values are high so the idle line gives no false falling edge
  always_comb
  begin
    rxSamples_next = {rxSamples_reg[1:0], rxSync2_reg};
    rxLevel_next   = (rxSamples_reg[0] & rxSamples_reg[1]) |
                     (rxSamples_reg[1] & rxSamples_reg[2]) |
                     (rxSamples_reg[0] & rxSamples_reg[2]);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxSync1_reg   <= 1'b1;
      rxSync2_reg   <= 1'b1;
      rxSamples_reg <= 3'h7;
      rxLevel_reg   <= 1'b1; // idle line is high
    end
    else
    begin
      rxSync1_reg   <= rxPin;
      rxSync2_reg   <= rxSync1_reg;
      rxSamples_reg <= rxSamples_next;
      rxLevel_reg   <= rxLevel_next;
    end
  end

  assign rdData     = rdData_reg;
  assign rateTick   = tick_reg;
  assign rxLevel    = rxLevel_reg;
  assign syncMaster = master_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // gapCount counts cycles since the last tick or restart; it loads one on a tick so
  // that a steady period and the first period after a restart give the same value
  logic [13:0] gapCount_reg;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      gapCount_reg <= 14'h0000;
    else if (divWrite || !genEnable)
      gapCount_reg <= 14'h0000;
    else if (tick_reg)
      gapCount_reg <= 14'h0001;
    else
      gapCount_reg <= gapCount_reg + 14'h0001;
  end

  AST_DIV_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(reset_n) |-> divisor_reg == 8'h00) else $error("divisor not zero after reset");
  AST_WRITE_CLEARS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    divWrite |=> timer_reg == 8'h00 && prescale_reg == 6'h00) else $error("timer not cleared by write");
  AST_SLAVE_QUIET: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !genEnable |=> !tick_reg) else $error("tick in sync slave mode");
  AST_PERIOD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(tick_reg) && $stable(txCtrl_reg) && $stable(divisor_reg) && genEnable
      |-> $past(gapCount_reg) == 14'(({6'h00, divisor_reg} + 14'h1) * ({8'h00, prescaleTop} + 14'h1) - 14'h1))
      else $error("tick period wrong");
  AST_SYNC_DIV4: assert property (@(posedge sys_clk) disable iff (!reset_n)
    syncMode |-> prescaleTop == PRESCALE_SYNC) else $error("sync prescale wrong");
  AST_HS_IGNORED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    syncMode && $changed(txCtrl_reg[TX_HIGH_SPEED_BIT]) |-> prescaleTop == PRESCALE_SYNC) else $error("hs bit used");
  AST_ASYNC_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !syncMode && !txCtrl_reg[TX_HIGH_SPEED_BIT] |-> prescaleTop == PRESCALE_ASYNC_LOW) else $error("low prescale");
  AST_ASYNC_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !syncMode && txCtrl_reg[TX_HIGH_SPEED_BIT] |-> prescaleTop == PRESCALE_ASYNC_HIGH) else $error("high prescale");
  AST_MAJORITY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxSamples_reg == 3'h7 |=> rxLevel_reg) else $error("majority high missed");
  AST_TIMER_BOUND: assert property (@(posedge sys_clk) disable iff (!reset_n)
    genEnable && !divWrite && timer_reg <= divisor_reg |=> timer_reg <= divisor_reg || $past(divWrite))
    else $error("timer beyond divisor");

  // tick and timer shape
  AST_TICK_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_reg |=> !tick_reg) else $error("tick longer than one cycle");
  AST_TICK_AT_WRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick_reg |-> timer_reg == 8'h00 && prescale_reg == 6'h00) else $error("tick off the wrap");
  AST_TIMER_STEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    genEnable && !divWrite && prescale_reg < prescaleTop |=> $stable(timer_reg)) else $error("timer moved early");
  AST_SLAVE_HELD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !genEnable |=> timer_reg == 8'h00 && prescale_reg == 6'h00) else $error("timer runs as slave");
  // mode flag
  AST_MASTER_FLAG: assert property (@(posedge sys_clk) disable iff (!reset_n)
    syncMode && txCtrl_reg[TX_CLOCK_SOURCE_BIT] |=> syncMaster) else $error("master flag missing");
  AST_ASYNC_NOT_MASTER: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !syncMode |=> !syncMaster) else $error("master flag in async mode");
  // register port
  AST_DIV_LANDS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    divWrite |=> divisor_reg == $past(busReq.wdata)) else $error("divisor write lost");
  AST_RD_DIVISOR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    busReq.rd && busReq.addr == ADDR_DIVISOR |=> rdData == $past(divisor_reg)) else $error("divisor read wrong");
  AST_TX_RO_BITS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (txCtrl_reg & ~TX_CTRL_WMASK) == (TX_CTRL_RESET & ~TX_CTRL_WMASK)) else $error("tx read-only bits moved");
  AST_RX_RO_BITS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rxCtrl_reg & ~RX_CTRL_WMASK) == 8'h00) else $error("rx read-only bits moved");
  // receive vote
  AST_MAJORITY_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rxSamples_reg == 3'h0 |=> !rxLevel_reg) else $error("majority low missed");
  AST_STATUS_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    busReq.rd && busReq.addr == ADDR_STATUS |=> rdData[2] == $past(rxLevel_reg)) else $error("status level wrong");

  COV_TICK_ASYNC: cover property (@(posedge sys_clk) disable iff (!reset_n) tick_reg && !syncMode);
  COV_TICK_SYNC: cover property (@(posedge sys_clk) disable iff (!reset_n) tick_reg && syncMode);
  COV_DIV_WRITE: cover property (@(posedge sys_clk) disable iff (!reset_n) divWrite && timer_reg != 8'h00);
  COV_RX_LOW: cover property (@(posedge sys_clk) disable iff (!reset_n) $fell(rxLevel_reg));
endmodule // brg_rate_generator

/* src/brg_pkg.sv */
// package for the serial port rate generator: register map, fields, reset values
package brg_pkg;
  localparam logic [1:0] ADDR_TX_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_RX_CTRL   = 2'h1;
  localparam logic [1:0] ADDR_DIVISOR   = 2'h2;
  localparam logic [1:0] ADDR_STATUS    = 2'h3;
  // transmit_control_status field positions
  localparam int TX_CLOCK_SOURCE_BIT = 7;
  localparam int TX_SYNC_MODE_BIT    = 4;
  localparam int TX_HIGH_SPEED_BIT   = 2;
  localparam int TX_SHIFT_EMPTY_BIT  = 1;
  localparam logic [7:0] TX_CTRL_RESET  = 8'h02;
  localparam logic [7:0] TX_CTRL_WMASK  = 8'hf5;
  localparam logic [7:0] RX_CTRL_RESET  = 8'h00;
  localparam logic [7:0] RX_CTRL_WMASK  = 8'hf8;
  localparam logic [7:0] DIVISOR_RESET  = 8'h00;
  // prescale divides: async low speed 64, async high 16, sync master 4
  localparam logic [5:0] PRESCALE_ASYNC_LOW  = 6'h3f;
  localparam logic [5:0] PRESCALE_ASYNC_HIGH = 6'h0f;
  localparam logic [5:0] PRESCALE_SYNC       = 6'h03;
  localparam logic [1:0] ADDR_RESERVED_NONE  = 2'h0;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } brg_bus_req_t;
endpackage : brg_pkg

/* tb/brg_line_model.sv */
// remote transmitter model that drives the receive data line
module brg_line_model
(
  input  wire logic sys_clk,
  input  wire logic sendLow,
  output logic      rxPin
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////////
  // line idles high; the far end moves it off the edge, unrelated to sampling
  initial rxPin = 1'b1;
  always @(posedge sys_clk)
  begin
    rxPin <= #1.3 ~sendLow;
  end
endmodule // brg_line_model

/* tb/brg_rate_generator_test.sv */
// self-checking bench for the rate generator
`define CHK(a, b) checks++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t mismatch", $time); end
module brg_rate_generator_test;
  timeunit 1ns;
  timeprecision 100ps;
  import brg_pkg::*;
  logic         sys_clk = 1'b0;
  logic         reset_n = 1'b0;
  brg_bus_req_t busReq  = '0;
  logic         sendLow = 1'b0;
  logic         rxPin;
  logic [7:0]   rdData;
  logic         rateTick;
  logic         rxLevel;
  logic         syncMaster;
  int           error_cnt = 0;
  int           checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #2 sys_clk = ~sys_clk;
  brg_rate_generator u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
    .rxPin(rxPin), .rateTick(rateTick), .rxLevel(rxLevel), .syncMaster(syncMaster));
  brg_line_model u_line (.sys_clk(sys_clk), .sendLow(sendLow), .rxPin(rxPin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq <= '0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    `CHK(rdData, e)
  endtask
  // counts edges to the next tick; a bound cuts a stuck generator short
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (rateTick !== 1'b1 && n < 20000);
    if (n >= 20000)
    begin
      error_cnt++;
      $display("BAD %0t no tick", $time);
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    rd_chk(ADDR_TX_CTRL, 8'h02);
    rd_chk(ADDR_RX_CTRL, 8'h00);
    rd_chk(ADDR_DIVISOR, 8'h00);
    rd_chk(ADDR_STATUS, 8'h05);
    `CHK(syncMaster, 1'b0)
  endtask
  // first tick bounded by one period proves the write restarted the timer
  task automatic rate(input logic [7:0] ctl, input logic [7:0] div, input int p, input logic sm);
    int n;
    int m;
    wr_reg(ADDR_TX_CTRL, ctl);
    repeat (5) @(posedge sys_clk);
    wr_reg(ADDR_DIVISOR, div);
    wait_tick(n);
    wait_tick(m);
    `CHK(m, (int'(div) + 1) * p)
    `CHK(n >= (int'(div) + 1) * p && n <= (int'(div) + 1) * p + 3, 1'b1)
    `CHK(syncMaster, sm)
  endtask
  task automatic slave_quiet();
    int t;
    t = 0;
    wr_reg(ADDR_TX_CTRL, 8'h14);
    repeat (300)
    begin
      @(posedge sys_clk);
      #1;
      t += int'(rateTick === 1'b1);
    end
    `CHK(t, 0)
    `CHK(syncMaster, 1'b0)
  endtask
  // a lone one-cycle dip must lose the vote, a held low must win it
  task automatic vote();
    int hi;
    hi = 0;
    @(posedge sys_clk);
    sendLow <= 1'b1;
    @(posedge sys_clk);
    sendLow <= 1'b0;
    repeat (10)
    begin
      @(posedge sys_clk);
      #1;
      hi += int'(rxLevel === 1'b1);
    end
    `CHK(hi, 10)
    @(posedge sys_clk);
    sendLow <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK(rxLevel, 1'b0)
    @(posedge sys_clk);
    sendLow <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK(rxLevel, 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    reset_values();
    rate(8'h00, 8'h02, 64, 1'b0);
    rate(8'h04, 8'h00, 16, 1'b0);
    rate(8'h04, 8'hff, 16, 1'b0);
    rate(8'h94, 8'h03, 4, 1'b1);
    rate(8'h90, 8'h00, 4, 1'b1);
    slave_quiet();
    wr_reg(ADDR_TX_CTRL, 8'hff);
    rd_chk(ADDR_TX_CTRL, 8'hf7);
    wr_reg(ADDR_DIVISOR, 8'h5a);
    rd_chk(ADDR_DIVISOR, 8'h5a);
    vote();
    do_reset();
    reset_values();
    finish_test();
  end
endmodule // brg_rate_generator_test
